/* hdl/fswp_pkg.sv */
/*
  Constants for the status and write-protection logic of a 64KB serial NOR flash:
  status bit positions, command codes, lock modes and operation kinds.
  Assumes a command framer that hands over one decoded command per pulse.
*/
`default_nettype none
package fswp_pkg;
  localparam int unsigned STAT_W = 16;
  localparam int unsigned ADDR_W = 24;
  localparam int unsigned SECT_N = 16;
  // Status bit positions.
  localparam int unsigned BIT_BUSY = 0;
  localparam int unsigned BIT_WEL = 1;
  localparam int unsigned AREA_LO = 2;
  localparam int unsigned AREA_HI = 6;
  localparam int unsigned BIT_LOCK_LO = 7;
  localparam int unsigned BIT_LOCK_HI = 8;
  localparam int unsigned BIT_QUAD = 9;
  localparam int unsigned BIT_PPAUSE = 10;
  localparam int unsigned SEC_LO = 11;
  localparam int unsigned SEC_HI = 13;
  localparam int unsigned BIT_CMP = 14;
  localparam int unsigned BIT_EPAUSE = 15;
  localparam logic [15:0] STAT_RESET = 16'h0000;
  // Bits that a status write may replace (area, lock, quad, complement).
  localparam logic [15:0] STAT_WR_MASK = 16'h43FC;
  // Command codes.
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_WRDI = 8'h04;
  localparam logic [7:0] CMD_SRW = 8'h01;
  localparam logic [7:0] CMD_PP = 8'h02;
  localparam logic [7:0] CMD_QPP = 8'h32;
  localparam logic [7:0] CMD_SECT = 8'h20;
  localparam logic [7:0] CMD_BLK32 = 8'h52;
  localparam logic [7:0] CMD_BLK64 = 8'hD8;
  localparam logic [7:0] CMD_CHIP_A = 8'hC7;
  localparam logic [7:0] CMD_CHIP_B = 8'h60;
  localparam logic [7:0] CMD_SUSP = 8'h75;
  localparam logic [7:0] CMD_RESM = 8'h7A;
  // Lock modes.
  localparam logic [1:0] LOCK_SOFT = 2'h0;
  localparam logic [1:0] LOCK_PIN = 2'h1;
  localparam logic [1:0] LOCK_POWER = 2'h2;
  localparam logic [1:0] LOCK_OTP = 2'h3;
  typedef enum logic [1:0] {FSWP_OP_NONE, FSWP_OP_PROG, FSWP_OP_ERASE, FSWP_OP_SRW} fswp_op_t;
endpackage
`default_nettype wire

/* hdl/fswp_top.sv */
/*
  Status register, lock modes and array protection decode of a 64KB serial flash.
  Assumes a command framer on clk giving one pulse per finished command with its
  code, address, status data and byte-boundary flag, an engine that reports the
  end of each started operation, and a non-volatile image of the status word.
  // How it works
  // - Busy bit zero is high while program, erase or status write runs.
  // - Bit one shows write latch; without it writes, programs, erases are refused.
  // - Area-select bits six to two are non-volatile, changed only by status write.
  // - Program and sector or block erase into the protected range are blocked.
  // - Hardware-protected lock state keeps the area-select bits unchanged.
  // - Chip erase only for low select 000 with complement 0, or 111 with 1.
  // - Complement 0 decode: none, 4/8/16/32KB top or bottom, or whole array.
  // - Complement 1 protects exactly what complement 0 leaves open.
  // - Mode 00 writes with latch; mode 01 also needs write-protect pin high.
  // - Mode 10 refuses status writes until power cycle, which restores 00.
  // - Mode 11 refuses every status write for good.
  // - Quad enable bit nine, default 0, turns pins into lanes two and three.
  // - Three one-time security lock bits thirteen to eleven, set only, never cleared.
  // - Complement bit fourteen is non-volatile read/write, default 0.
  // - Suspend sets erase-paused bit fifteen or program-paused bit ten.
  // - Resume and power cycle clear both paused flags.
  // - Write, program, erase and latch commands off a byte boundary are dropped.
*/
`default_nettype none
module fswp_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [23:0] cmd_addr,
  input wire logic [15:0] cmd_data,
  input wire logic cmd_byte_aligned,
  input wire logic op_done,
  input wire logic [15:0] nv_image,
  input wire logic wp_n_pin,
  output logic [15:0] status_q,
  output logic op_start_q,
  output fswp_pkg::fswp_op_t op_kind_q,
  output logic cmd_refused_q,
  output logic nv_wr_q,
  output logic [15:0] nv_wr_data_q,
  output logic quad_mode_q,
  output logic [2:0] secure_ro_q
);
  logic wp_meta_q;
  logic wp_sync_q;
  logic load_pend_q;
  fswp_pkg::fswp_op_t run_kind_q;
  logic [15:0] status_d;
  logic op_start_d;
  fswp_pkg::fswp_op_t op_kind_d;
  fswp_pkg::fswp_op_t run_kind_d;
  logic refused_d;
  logic nv_wr_d;
  logic [15:0] nv_wr_data_d;

  wire logic busy = status_q[fswp_pkg::BIT_BUSY];
  wire logic write_latch_flag = status_q[fswp_pkg::BIT_WEL];
  wire logic [4:0] area = status_q[fswp_pkg::AREA_HI:fswp_pkg::AREA_LO];
  wire logic [1:0] lock_mode = {status_q[fswp_pkg::BIT_LOCK_HI], status_q[fswp_pkg::BIT_LOCK_LO]};
  wire logic quad_on = status_q[fswp_pkg::BIT_QUAD];
  wire logic cmp_on = status_q[fswp_pkg::BIT_CMP];
  wire logic paused = status_q[fswp_pkg::BIT_EPAUSE] | status_q[fswp_pkg::BIT_PPAUSE];
  wire logic [2:0] sec_lock = status_q[fswp_pkg::SEC_HI:fswp_pkg::SEC_LO];

  // With quad lanes on, the write-protect function of the pin is gone.
  wire logic wp_high = quad_on | wp_sync_q;
  wire logic hw_locked = (lock_mode == fswp_pkg::LOCK_PIN) && !wp_high;

  // Command decode.
  wire logic is_wren = cmd_valid && (cmd_code == fswp_pkg::CMD_WREN);
  wire logic is_wrdi = cmd_valid && (cmd_code == fswp_pkg::CMD_WRDI);
  wire logic is_srw = cmd_valid && (cmd_code == fswp_pkg::CMD_SRW);
  wire logic is_prog = cmd_valid && ((cmd_code == fswp_pkg::CMD_PP) || (cmd_code == fswp_pkg::CMD_QPP));
  wire logic is_sect = cmd_valid && (cmd_code == fswp_pkg::CMD_SECT);
  wire logic is_b32 = cmd_valid && (cmd_code == fswp_pkg::CMD_BLK32);
  wire logic is_b64 = cmd_valid && (cmd_code == fswp_pkg::CMD_BLK64);
  wire logic is_chip = cmd_valid && ((cmd_code == fswp_pkg::CMD_CHIP_A) ||
                                     (cmd_code == fswp_pkg::CMD_CHIP_B));
  wire logic is_susp = cmd_valid && (cmd_code == fswp_pkg::CMD_SUSP);
  wire logic is_resm = cmd_valid && (cmd_code == fswp_pkg::CMD_RESM);
  wire logic needs_align = is_wren | is_wrdi | is_srw | is_prog | is_sect | is_b32 | is_b64 | is_chip;
  wire logic misaligned = needs_align && !cmd_byte_aligned;
  // A paused operation or a pending load refuses every new write.
  wire logic may_write = write_latch_flag && !busy && !paused && !load_pend_q && cmd_byte_aligned;

  // sector count of the complement-0 region, in 4KB sectors.
  wire logic [4:0] prot_n = !area[4] ? ((area[1:0] == 2'h0) ? 5'h00 : 5'h10) :
                            (area[2:0] == 3'h0) ? 5'h00 :
                            (area[2:0] == 3'h1) ? 5'h01 :
                            (area[2:0] == 3'h2) ? 5'h02 :
                            (area[2:0] == 3'h3) ? 5'h04 :
                            (area[2:0] == 3'h7) ? 5'h10 : 5'h08;
  wire logic [31:0] ones_low = (32'h0000_0001 << prot_n) - 32'h0000_0001;
  wire logic [15:0] low_mask = ones_low[15:0];
  wire logic [15:0] up_mask = {<<{low_mask}};
  // select bit three picks the lower end.
  wire logic [15:0] base_mask = (area[4] && area[3]) ? low_mask :
                                (area[4] ? up_mask : low_mask);
  wire logic [15:0] prot_mask = cmp_on ? ~base_mask : base_mask;

  wire logic [3:0] sect_idx = cmd_addr[15:12];
  wire logic [15:0] one_sect = 16'h0001 << sect_idx;
  wire logic [15:0] target_mask = is_b64 ? 16'hFFFF :
                                  is_b32 ? (cmd_addr[15] ? 16'hFF00 : 16'h00FF) : one_sect;
  // any overlap with protected sectors blocks the command.
  wire logic area_hit = |(prot_mask & target_mask);
  wire logic chip_ok = ((area[2:0] == 3'h0) && !cmp_on) || ((area[2:0] == 3'h7) && cmp_on);

  wire logic lock_ok = (lock_mode == fswp_pkg::LOCK_SOFT) ||
                       ((lock_mode == fswp_pkg::LOCK_PIN) && wp_high);
  wire logic srw_go = is_srw && may_write && lock_ok;
  wire logic prog_go = is_prog && may_write && !area_hit;
  wire logic erase_go = ((is_sect | is_b32 | is_b64) && !area_hit || is_chip && chip_ok) && may_write;
  wire logic susp_go = is_susp && busy &&
                       ((run_kind_q == fswp_pkg::FSWP_OP_PROG) || (run_kind_q == fswp_pkg::FSWP_OP_ERASE));
  wire logic resm_go = is_resm && paused && !busy;

  wire logic [15:0] srw_image = (status_q & ~fswp_pkg::STAT_WR_MASK) |
                                (cmd_data & fswp_pkg::STAT_WR_MASK) |
                                {2'h0, sec_lock | cmd_data[fswp_pkg::SEC_HI:fswp_pkg::SEC_LO], 11'h000};
  // power cycle turns mode 10 back to 00; volatile bits start clear.
  wire logic [1:0] nv_lock = {nv_image[fswp_pkg::BIT_LOCK_HI], nv_image[fswp_pkg::BIT_LOCK_LO]};
  wire logic [15:0] nv_keep = nv_image & (fswp_pkg::STAT_WR_MASK | 16'h3800);
  wire logic [15:0] load_image = (nv_lock == fswp_pkg::LOCK_POWER) ?
                                 (nv_keep & ~16'h0180) : nv_keep;

  // At most one action is taken per cycle; a command that loses is dropped.
  always_comb begin
    status_d = status_q;
    op_start_d = 1'b0;
    op_kind_d = fswp_pkg::FSWP_OP_NONE;
    run_kind_d = run_kind_q;
    refused_d = 1'b0;
    nv_wr_d = 1'b0;
    nv_wr_data_d = nv_wr_data_q;
    if (load_pend_q) begin
      // non-volatile fields come from the stored image.
      status_d = load_image;
    end else if (misaligned) begin
      refused_d = 1'b1;
    end else if (srw_go) begin
      // area bits change only here and never when pin-locked.
      status_d = srw_image | 16'h0001;
      op_start_d = 1'b1;
      op_kind_d = fswp_pkg::FSWP_OP_SRW;
      run_kind_d = fswp_pkg::FSWP_OP_SRW;
      nv_wr_d = 1'b1;
      nv_wr_data_d = srw_image & ~16'h0003;
    end else if (prog_go || erase_go) begin
      status_d[fswp_pkg::BIT_BUSY] = 1'b1;
      op_start_d = 1'b1;
      op_kind_d = prog_go ? fswp_pkg::FSWP_OP_PROG : fswp_pkg::FSWP_OP_ERASE;
      run_kind_d = op_kind_d;
    end else if (susp_go) begin
      // flag follows the kind of the paused operation.
      status_d[fswp_pkg::BIT_BUSY] = 1'b0;
      if (run_kind_q == fswp_pkg::FSWP_OP_ERASE) begin
        status_d[fswp_pkg::BIT_EPAUSE] = 1'b1;
      end else begin
        status_d[fswp_pkg::BIT_PPAUSE] = 1'b1;
      end
    end else if (resm_go) begin
      // resume clears both flags and the operation runs on.
      status_d[fswp_pkg::BIT_EPAUSE] = 1'b0;
      status_d[fswp_pkg::BIT_PPAUSE] = 1'b0;
      status_d[fswp_pkg::BIT_BUSY] = 1'b1;
    end else if (busy && op_done) begin
      // the finished operation also drops the latch.
      status_d[fswp_pkg::BIT_BUSY] = 1'b0;
      status_d[fswp_pkg::BIT_WEL] = 1'b0;
      run_kind_d = fswp_pkg::FSWP_OP_NONE;
    end else if ((is_wren || is_wrdi) && !busy) begin
      // latch set and cleared by its own commands.
      status_d[fswp_pkg::BIT_WEL] = is_wren;
    end else if (is_srw || is_prog || is_sect || is_b32 || is_b64 || is_chip) begin
      refused_d = 1'b1;
    end
  end

  // Two flops bring the asynchronous write-protect pin into the clock domain.
  always_ff @(posedge clk) begin
    wp_meta_q <= wp_n_pin;
    wp_sync_q <= wp_meta_q;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_q <= fswp_pkg::STAT_RESET;
      load_pend_q <= 1'b1;
      run_kind_q <= fswp_pkg::FSWP_OP_NONE;
      op_start_q <= 1'b0;
      op_kind_q <= fswp_pkg::FSWP_OP_NONE;
      cmd_refused_q <= 1'b0;
      nv_wr_q <= 1'b0;
      nv_wr_data_q <= fswp_pkg::STAT_RESET;
      quad_mode_q <= 1'b0;
      secure_ro_q <= 3'h0;
    end else begin
      status_q <= status_d;
      load_pend_q <= 1'b0;
      run_kind_q <= run_kind_d;
      op_start_q <= op_start_d;
      op_kind_q <= op_kind_d;
      cmd_refused_q <= refused_d;
      nv_wr_q <= nv_wr_d;
      nv_wr_data_q <= nv_wr_data_d;
      // pin function and read-only areas follow the status.
      quad_mode_q <= status_d[fswp_pkg::BIT_QUAD];
      secure_ro_q <= status_d[fswp_pkg::SEC_HI:fswp_pkg::SEC_LO];
    end
  end

  // Checks below that the load could upset skip the load cycle, when the stored image replaces the status.
  a_busy_on_start: assert property (@(posedge clk) disable iff (sys_rst)
    op_start_q |-> status_q[0])
    else $error("busy low at start");
  a_latch_gates_start: assert property (@(posedge clk) disable iff (sys_rst)
    op_start_q |-> $past(status_q[1]))
    else $error("start without latch");
  a_area_pin_lock: assert property (@(posedge clk) disable iff (sys_rst)
    $past(hw_locked) && !$past(load_pend_q) |-> status_q[6:2] == $past(status_q[6:2]))
    else $error("area bits changed while locked");
  a_area_only_write: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(srw_go) && !$past(load_pend_q) |-> $stable(status_q[6:2]))
    else $error("area bits changed without write");
  a_prot_blocks: assert property (@(posedge clk) disable iff (sys_rst)
    $past(is_prog || is_sect || is_b32 || is_b64) && $past(area_hit) |-> !op_start_q)
    else $error("protected target started");
  a_chip_gate: assert property (@(posedge clk) disable iff (sys_rst)
    $past(is_chip) && op_start_q |-> $past(chip_ok))
    else $error("chip erase bad code");
  a_otp_no_write: assert property (@(posedge clk) disable iff (sys_rst)
    $past(status_q[8:7]) == 2'h3 && !$past(load_pend_q) |-> !nv_wr_q)
    else $error("write in locked mode");
  a_otp_area_hold: assert property (@(posedge clk) disable iff (sys_rst)
    (lock_mode == fswp_pkg::LOCK_OTP) && !load_pend_q |=> $stable(status_q[6:2]))
    else $error("area changed in locked mode");
  a_secure_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    !$past(load_pend_q) |-> ($past(status_q[13:11]) & ~status_q[13:11]) == 3'h0)
    else $error("security bit cleared");
  a_secure_follows: assert property (@(posedge clk) disable iff (sys_rst)
    secure_ro_q == status_q[13:11])
    else $error("read-only areas differ from status");
  a_quad_follows: assert property (@(posedge clk) disable iff (sys_rst)
    quad_mode_q == status_q[9])
    else $error("quad mode differs from status");
  a_pause_flag: assert property (@(posedge clk) disable iff (sys_rst)
    susp_go |=> (status_q[15] || status_q[10]) && !status_q[0])
    else $error("no pause flag");
  a_erase_pause_kind: assert property (@(posedge clk) disable iff (sys_rst)
    susp_go && (run_kind_q == fswp_pkg::FSWP_OP_ERASE) |=> status_q[15] && !status_q[10])
    else $error("wrong pause flag");
  a_resume_clear: assert property (@(posedge clk) disable iff (sys_rst)
    resm_go |=> !status_q[15] && !status_q[10] && status_q[0])
    else $error("flags kept");
  a_misalign_drop: assert property (@(posedge clk) disable iff (sys_rst)
    misaligned && !load_pend_q |=> cmd_refused_q && $stable(status_q))
    else $error("odd end taken");
  a_misalign_no_start: assert property (@(posedge clk) disable iff (sys_rst)
    misaligned && !load_pend_q |=> !op_start_q && !nv_wr_q)
    else $error("odd end started work");
  a_powerup_clear: assert property (@(posedge clk)
    $past(sys_rst) && !sys_rst |-> !status_q[0] && !status_q[1])
    else $error("volatile bits set");
  a_reload_clean: assert property (@(posedge clk) disable iff (sys_rst)
    $past(load_pend_q) && !$past(sys_rst) |-> status_q[8:7] != 2'h2 && status_q[15:14] != 2'h3)
    else $error("reload kept power lock");
  a_done_clears: assert property (@(posedge clk) disable iff (sys_rst)
    busy && op_done && !cmd_valid && !load_pend_q |=> !status_q[0] && !status_q[1])
    else $error("busy kept after done");
  a_busy_no_start: assert property (@(posedge clk) disable iff (sys_rst)
    busy && !load_pend_q |=> !op_start_q)
    else $error("start while busy");
  a_no_latch_refuse: assert property (@(posedge clk) disable iff (sys_rst)
    (is_srw || is_prog || is_sect || is_b32 || is_b64 || is_chip) && !write_latch_flag |=> !op_start_q)
    else $error("start without latch set");
  a_power_lock: assert property (@(posedge clk) disable iff (sys_rst)
    (lock_mode == fswp_pkg::LOCK_POWER) && !load_pend_q |=> !nv_wr_q)
    else $error("write in power lock");
  a_pin_lock_write: assert property (@(posedge clk) disable iff (sys_rst)
    hw_locked && !load_pend_q |=> !nv_wr_q)
    else $error("write while pin locked");
  a_nv_word: assert property (@(posedge clk) disable iff (sys_rst)
    nv_wr_q |-> nv_wr_data_q == (status_q & 16'hFFFC))
    else $error("stored word differs from status");
endmodule // fswp_top
`default_nettype wire

/* dv/fswp_host.sv */
/*
  Host controller model: hands one finished command at a time to the flash logic.
  Assumes the caller waits for each call to return before issuing the next.
*/
`default_nettype none
module fswp_host (
  input wire logic clk,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [23:0] cmd_addr,
  output logic [15:0] cmd_data,
  output logic cmd_byte_aligned
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_valid = 1'h0;
    cmd_code = 8'hFF;
    cmd_addr = 24'hFFFFFF;
    cmd_data = 16'hFFFF;
    cmd_byte_aligned = 1'h0;
  end
  // byte boundary framing
  // Released fields are inverted so that stale values are never mistaken for live ones.
  task automatic send(input logic [7:0] c, input logic [23:0] a, input logic [15:0] d,
      input logic al);
    @(posedge clk);
    cmd_valid <= 1'h1;
    cmd_code <= c;
    cmd_addr <= a;
    cmd_data <= d;
    cmd_byte_aligned <= al;
    @(posedge clk);
    cmd_valid <= 1'h0;
    cmd_code <= ~c;
    cmd_addr <= ~a;
    cmd_data <= ~d;
    cmd_byte_aligned <= ~al;
  endtask
endmodule // fswp_host
`default_nettype wire

/* dv/flash_status_write_protect_bench.sv */
/*
  Self-checking bench for the flash status and write-protection logic.
  Assumes the host model drives commands and the bench plays engine and storage.
*/
`default_nettype none
module flash_status_write_protect_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, cmd_valid, cmd_byte_aligned, op_done, wp_n_pin;
  logic op_start_q, cmd_refused_q, nv_wr_q, quad_mode_q, r;
  logic [7:0] cmd_code, c;
  logic [23:0] cmd_addr;
  logic [15:0] cmd_data, nv_image, status_q, nv_wr_data_q, rnd, st;
  logic [2:0] secure_ro_q;
  fswp_pkg::fswp_op_t op_kind_q;
  int fail_count, compares;
  int nb, sb;
  logic [2:0] sa;
  fswp_top fswp_top_inst (.clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_byte_aligned(cmd_byte_aligned), .op_done(op_done), .nv_image(nv_image),
    .wp_n_pin(wp_n_pin), .status_q(status_q), .op_start_q(op_start_q),
    .op_kind_q(op_kind_q), .cmd_refused_q(cmd_refused_q), .nv_wr_q(nv_wr_q),
    .nv_wr_data_q(nv_wr_data_q), .quad_mode_q(quad_mode_q), .secure_ro_q(secure_ro_q));
  fswp_host fswp_host_inst (.clk(clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_byte_aligned(cmd_byte_aligned));
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Protected-or-not for a 4KB sector under a select code and complement.
  function automatic logic prot(input logic [4:0] a, input logic cm, input logic [15:0] ad);
    int n;
    logic p;
    case (a[2:0])
      3'h1: n = 1;
      3'h2: n = 2;
      3'h3: n = 4;
      default: n = 8;
    endcase
    if (!a[4]) p = a[1:0] != 2'h0;
    else if (a[2:0] == 3'h0) p = 1'h0;
    else if (a[2:0] == 3'h7) p = 1'h1;
    else p = a[3] ? (int'(ad[15:12]) < n) : (int'(ad[15:12]) >= 16 - n);
    return p ^ cm;
  endfunction
  function automatic logic [15:0] img(input logic [15:0] v);
    logic [15:0] e;
    e = v & 16'h7BFC;
    if (v[8:7] == 2'h2) e[8:7] = 2'h0;
    return e;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic op(input logic [7:0] k, input logic [15:0] a, input logic [15:0] d,
      input logic al, input logic rf);
    fswp_host_inst.send(k, {8'h00, a}, d, al);
    #1;
    chk("cmd_refused_q", {15'h0000, rf}, {15'h0000, cmd_refused_q});
  endtask
  task automatic done();
    @(posedge clk);
    op_done <= 1'h1;
    @(posedge clk);
    op_done <= 1'h0;
    #1;
  endtask
  task automatic wrs(input logic [15:0] d);
    op(fswp_pkg::CMD_WREN, 16'h0000, 16'h0000, 1'h1, 1'h0);
    op(fswp_pkg::CMD_SRW, 16'h0000, d, 1'h1, 1'h0);
    chk("busy", 16'h0001, {15'h0000, status_q[0]});
    chk("op_kind_q", 16'h0003, {14'h0000, op_kind_q});
    chk("op_start_q", 16'h0001, {15'h0000, op_start_q});
    chk("nv_wr_q", 16'h0001, {15'h0000, nv_wr_q});
    chk("nv_wr_data_q", (d & 16'h43FC) | {2'h0, sa | d[13:11], 11'h000}, nv_wr_data_q);
    sa = sa | d[13:11];
    done();
    chk("latch_busy", 16'h0000, {14'h0000, status_q[1:0]});
  endtask
  task automatic rst(input logic [15:0] v);
    @(posedge clk);
    nv_image <= v;
    sys_rst <= 1'h1;
    repeat (12) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic results();
    if (fail_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #1000000;
    fail_count++;
    results();
  end
  initial begin
    sys_rst = 1'h1;
    op_done = 1'h0;
    wp_n_pin = 1'h1;
    nv_image = 16'h0000;
    fail_count = 0;
    compares = 0;
    sa = 3'h0;
    rnd = 16'hA372;
    rst(16'h0000);
    chk("status", 16'h0000, status_q);
    op(fswp_pkg::CMD_WREN, 16'h0000, 16'h0000, 1'h0, 1'h1);
    op(fswp_pkg::CMD_SRW, 16'h0000, 16'h0004, 1'h1, 1'h1);
    chk("status", 16'h0000, status_q);
    op(fswp_pkg::CMD_WREN, 16'h0000, 16'h0000, 1'h1, 1'h0);
    chk("latch", 16'h0002, status_q & 16'h0002);
    op(fswp_pkg::CMD_WRDI, 16'h0000, 16'h0000, 1'h1, 1'h0);
    op(fswp_pkg::CMD_SRW, 16'h0000, 16'h0004, 1'h1, 1'h1);
    repeat (24) begin
      rnd = lfsr(rnd);
      st = {1'h0, rnd[14], 4'h0, rnd[9], 2'h0, rnd[6:2], 2'h0};
      wrs(st);
      chk("status", st, status_q);
      chk("quad", {15'h0000, st[9]}, {15'h0000, quad_mode_q});
      rnd = lfsr(rnd);
      op(fswp_pkg::CMD_WREN, 16'h0000, 16'h0000, 1'h1, 1'h0);
      if (rnd[1]) begin
        c = rnd[0] ? fswp_pkg::CMD_CHIP_A : fswp_pkg::CMD_CHIP_B;
        r = !((st[4:2] == 3'h0 && !st[14]) || (st[4:2] == 3'h7 && st[14]));
      end else begin
        case (rnd[3:2])
          2'h0: c = fswp_pkg::CMD_PP;
          2'h1: c = fswp_pkg::CMD_SECT;
          2'h2: c = fswp_pkg::CMD_BLK32;
          default: c = fswp_pkg::CMD_BLK64;
        endcase
        nb = (c == fswp_pkg::CMD_BLK64) ? 16 : (c == fswp_pkg::CMD_BLK32) ? 8 : 1;
        sb = (nb == 16) ? 0 : (nb == 8) ? 8 * int'(rnd[15]) : int'(rnd[15:12]);
        r = 1'h0;
        for (int s = sb; s < sb + nb; s++) r = r | prot(st[6:2], st[14], 16'(s) << 12);
      end
      op(c, rnd, 16'h0000, 1'h1, r);
      chk("op_start_q", {15'h0000, !r}, {15'h0000, op_start_q});
      if (!r) chk("op_kind_q", (c == fswp_pkg::CMD_PP) ? 16'h0001 : 16'h0002,
          {14'h0000, op_kind_q});
      if (!r) done();
    end
    wrs(16'h0000);
    for (int k = 0; k < 2; k++) begin
      op(fswp_pkg::CMD_WREN, 16'h0000, 16'h0000, 1'h1, 1'h0);
      op(k ? fswp_pkg::CMD_PP : fswp_pkg::CMD_SECT, 16'h1000, 16'h0000, 1'h1, 1'h0);
      op(fswp_pkg::CMD_SUSP, 16'h0000, 16'h0000, 1'h1, 1'h0);
      chk("paused", k ? 16'h0400 : 16'h8000, status_q & 16'h8401);
      op(fswp_pkg::CMD_RESM, 16'h0000, 16'h0000, 1'h1, 1'h0);
      chk("paused", 16'h0001, status_q & 16'h8401);
      done();
    end
    wrs(16'h0800);
    wrs(16'h1000);
    chk("secure", 16'h0003, {13'h0000, secure_ro_q});
    wrs(16'h18FC);
    @(posedge clk);
    wp_n_pin <= 1'h0;
    repeat (3) @(posedge clk);
    op(fswp_pkg::CMD_WREN, 16'h0000, 16'h0000, 1'h1, 1'h0);
    op(fswp_pkg::CMD_SRW, 16'h0000, 16'h1880, 1'h1, 1'h1);
    chk("status", 16'h18FE, status_q);
    @(posedge clk);
    wp_n_pin <= 1'h1;
    repeat (3) @(posedge clk);
    wrs(16'h1900);
    op(fswp_pkg::CMD_WREN, 16'h0000, 16'h0000, 1'h1, 1'h0);
    op(fswp_pkg::CMD_SRW, 16'h0000, 16'h0000, 1'h1, 1'h1);
    rst(16'h9D47);
    chk("status", img(16'h9D47), status_q);
    rst(16'h0180);
    op(fswp_pkg::CMD_WREN, 16'h0000, 16'h0000, 1'h1, 1'h0);
    op(fswp_pkg::CMD_SRW, 16'h0000, 16'h0000, 1'h1, 1'h1);
    results();
  end
endmodule // flash_status_write_protect_bench
`default_nettype wire
